// ---- hdl/fts_pkg.sv ----
// Constants, register map and carrier types for the fault and thermal status bank
package fts_pkg;

	localparam int          FTS_DATA_W    = 8;
	localparam int          FTS_ADDR_W    = 8;
	localparam int          FTS_FLAG_N    = 5;

	localparam logic [7:0]  FTS_OFS_RAIL  = 8'hB3;
	localparam logic [7:0]  FTS_OFS_CRIT  = 8'hB4;
	localparam logic [7:0]  FTS_OFS_HOT   = 8'hB5;

	localparam logic [4:0]  FTS_FLAG_RST  = 5'h00;
	localparam logic [7:0]  FTS_RD_ZERO   = 8'h00;

	// Bit positions inside each register
	localparam int          FTS_B_ADJ1    = 4;
	localparam int          FTS_B_TERM    = 3;
	localparam int          FTS_B_LOAD_SWITCH_B_TWO    = 2;
	localparam int          FTS_B_LOAD_SWITCH_B_ONE    = 1;
	localparam int          FTS_B_ADJ3    = 0;
	localparam int          FTS_B_DIE     = 4;
	localparam int          FTS_B_URIGHT  = 2;
	localparam int          FTS_B_ULEFT   = 1;
	localparam int          FTS_B_LRIGHT  = 0;

	// Register access from the serial engine
	typedef struct packed {
		logic                  wr_en;
		logic                  rd_en;
		logic [7:0]            addr;
		logic [7:0]            wdata;
	} fts_req_t;

	// Event inputs, one bit per source, at the register bit positions
	typedef struct packed {
		logic [4:0]            rail_fault;
		logic [4:0]            over_crit;
		logic [4:0]            over_hot;
	} fts_evt_t;

	// All module state
	typedef struct packed {
		logic [4:0]            rail_flags;
		logic [4:0]            crit_flags;
		logic [4:0]            hot_flags;
		logic [7:0]            rdata;
		logic                  rvalid;
	} fts_state_t;

endpackage : fts_pkg

// ---- hdl/fts_status_bank.sv ----
// Sticky rail-fault and temperature status registers behind the register port
module fts_status_bank
	import fts_pkg::*;
#(
	// Flag count and bus widths
	parameter int FLAG_N = FTS_FLAG_N,
	parameter int DATA_W = FTS_DATA_W,
	parameter int ADDR_W = FTS_ADDR_W
)
(
	// Clock and reset
	input  wire logic              CLOCK,
	input  wire logic              RST,
	input  wire logic              CLK_EN,
	// Register port from the serial engine
	input  wire fts_req_t          REQ,
	output logic [7:0]             RDATA,
	output logic                   RVALID,
	// Event levels from rail monitors and sensors
	input  wire fts_evt_t          EVT,
	// Live flag view
	output logic [4:0]             RAIL_FLAGS,
	output logic [4:0]             CRIT_FLAGS,
	output logic [4:0]             HOT_FLAGS
);

	// Register map selection, shared by write and read decode
	typedef enum {
		SEL_NONE,
		SEL_RAIL,
		SEL_CRIT,
		SEL_HOT
	} fts_sel_t;

	// State and its next value
	fts_state_t              state_reg;
	fts_state_t              state_next;

	// Port decode
	logic                    wr_take;
	logic                    rd_take;
	fts_sel_t                wr_sel;
	fts_sel_t                rd_sel;
	logic                    wr_rail_hit;
	logic                    wr_crit_hit;
	logic                    wr_hot_hit;

	// Per-register clear, set and next vectors
	logic [FLAG_N-1:0]       rail_clr;
	logic [FLAG_N-1:0]       crit_clr;
	logic [FLAG_N-1:0]       hot_clr;
	logic [FLAG_N-1:0]       rail_set;
	logic [FLAG_N-1:0]       crit_set;
	logic [FLAG_N-1:0]       hot_set;
	logic [FLAG_N-1:0]       rail_nxt;
	logic [FLAG_N-1:0]       crit_nxt;
	logic [FLAG_N-1:0]       hot_nxt;

	// Read word for the addressed register
	logic [DATA_W-1:0]       rd_word;

	// Rail monitor sources
	logic                    adj_reg1_loss;
	logic                    term_reg_loss;
	logic                    switch_b2_loss;
	logic                    switch_b1_loss;
	logic                    adj_reg3_loss;

	// Critical comparator sources
	logic                    die_over_crit;
	logic                    term_over_crit;
	logic                    uright_over_crit;
	logic                    uleft_over_crit;
	logic                    lright_over_crit;

	// Hot comparator sources
	logic                    die_over_hot;
	logic                    term_over_hot;
	logic                    uright_over_hot;
	logic                    uleft_over_hot;
	logic                    lright_over_hot;

	// Named rail flags
	logic                    adj_reg1_fault_flag;
	logic                    termination_reg_fault_flag;
	logic                    switch_b2_fault_flag;
	logic                    switch_b1_fault_flag;
	logic                    adj_reg3_fault_flag;

	// Named critical flags
	logic                    rest_of_die_critical_flag;
	logic                    termination_reg_critical_flag;
	logic                    upper_right_critical_flag;
	logic                    upper_left_critical_flag;
	logic                    lower_right_critical_flag;

	// One decode for both directions keeps reads and writes on the same map
	function automatic fts_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
		fts_sel_t sel;
		unique case (addr)
			FTS_OFS_RAIL: begin
				sel = SEL_RAIL;
			end
			FTS_OFS_CRIT: begin
				sel = SEL_CRIT;
			end
			FTS_OFS_HOT: begin
				sel = SEL_HOT;
			end
			default: begin
				sel = SEL_NONE;
			end
		endcase
		return sel;
	endfunction : decode_sel

	// Write strobe aimed at one register
	function automatic logic wr_hit(
		input logic     take,
		input fts_sel_t sel,
		input fts_sel_t want
	);
		return take && (sel == want);
	endfunction : wr_hit

	function automatic logic [FLAG_N-1:0] clear_mask(
		input logic              hit,
		input logic [DATA_W-1:0] wd
	);
		logic [FLAG_N-1:0] mask;
		mask = '0;
		if (hit) begin
			mask = wd[FLAG_N-1:0];
		end
		return mask;
	endfunction : clear_mask

	function automatic logic flag_next(
		input logic cur,
		input logic set,
		input logic clr
	);
		logic keep;
		keep = cur & ~clr;
		return keep | set;
	endfunction : flag_next

	function automatic logic [DATA_W-1:0] read_word(
		input fts_sel_t          sel,
		input logic [FLAG_N-1:0] rail,
		input logic [FLAG_N-1:0] crit,
		input logic [FLAG_N-1:0] hot
	);
		logic [DATA_W-1:0] word;
		unique case (sel)
			SEL_RAIL: begin
				word = DATA_W'(rail);
			end
			SEL_CRIT: begin
				word = DATA_W'(crit);
			end
			SEL_HOT: begin
				word = DATA_W'(hot);
			end
			SEL_NONE: begin
				word = FTS_RD_ZERO;
			end
		endcase
		return word;
	endfunction : read_word

	assign adj_reg1_loss    = EVT.rail_fault[FTS_B_ADJ1];
	assign term_reg_loss    = EVT.rail_fault[FTS_B_TERM];
	assign switch_b2_loss   = EVT.rail_fault[FTS_B_LOAD_SWITCH_B_TWO];
	assign switch_b1_loss   = EVT.rail_fault[FTS_B_LOAD_SWITCH_B_ONE];
	assign adj_reg3_loss    = EVT.rail_fault[FTS_B_ADJ3];

	assign rail_set[FTS_B_ADJ1] = adj_reg1_loss;
	assign rail_set[FTS_B_TERM] = term_reg_loss;
	assign rail_set[FTS_B_LOAD_SWITCH_B_TWO] = switch_b2_loss;
	assign rail_set[FTS_B_LOAD_SWITCH_B_ONE] = switch_b1_loss;
	assign rail_set[FTS_B_ADJ3] = adj_reg3_loss;

	assign die_over_crit    = EVT.over_crit[FTS_B_DIE];
	assign term_over_crit   = EVT.over_crit[FTS_B_TERM];
	assign uright_over_crit = EVT.over_crit[FTS_B_URIGHT];
	assign uleft_over_crit  = EVT.over_crit[FTS_B_ULEFT];
	assign lright_over_crit = EVT.over_crit[FTS_B_LRIGHT];

	assign crit_set[FTS_B_DIE]    = die_over_crit;
	assign crit_set[FTS_B_TERM]   = term_over_crit;
	assign crit_set[FTS_B_URIGHT] = uright_over_crit;
	assign crit_set[FTS_B_ULEFT]  = uleft_over_crit;
	assign crit_set[FTS_B_LRIGHT] = lright_over_crit;

	assign die_over_hot     = EVT.over_hot[FTS_B_DIE];
	assign term_over_hot    = EVT.over_hot[FTS_B_TERM];
	assign uright_over_hot  = EVT.over_hot[FTS_B_URIGHT];
	assign uleft_over_hot   = EVT.over_hot[FTS_B_ULEFT];
	assign lright_over_hot  = EVT.over_hot[FTS_B_LRIGHT];

	assign hot_set[FTS_B_DIE]    = die_over_hot;
	assign hot_set[FTS_B_TERM]   = term_over_hot;
	assign hot_set[FTS_B_URIGHT] = uright_over_hot;
	assign hot_set[FTS_B_ULEFT]  = uleft_over_hot;
	assign hot_set[FTS_B_LRIGHT] = lright_over_hot;

	// Register port decode
	assign wr_take     = REQ.wr_en;
	assign rd_take     = REQ.rd_en;
	assign wr_sel      = decode_sel(REQ.addr);
	assign rd_sel      = decode_sel(REQ.addr);

	assign wr_rail_hit = wr_hit(wr_take, wr_sel, SEL_RAIL);
	assign wr_crit_hit = wr_hit(wr_take, wr_sel, SEL_CRIT);
	assign wr_hot_hit  = wr_hit(wr_take, wr_sel, SEL_HOT);
	assign rail_clr    = clear_mask(wr_rail_hit, REQ.wdata);
	assign crit_clr    = clear_mask(wr_crit_hit, REQ.wdata);
	assign hot_clr     = clear_mask(wr_hot_hit, REQ.wdata);

	for (genvar gi = 0; gi < FLAG_N; gi++) begin : g_rail
		logic cur;
		logic set;
		logic clr;
		assign cur = state_reg.rail_flags[gi];
		assign set = rail_set[gi];
		assign clr = rail_clr[gi];
		assign rail_nxt[gi] = flag_next(cur, set, clr);
	end

	for (genvar gi = 0; gi < FLAG_N; gi++) begin : g_crit
		logic cur;
		logic set;
		logic clr;
		assign cur = state_reg.crit_flags[gi];
		assign set = crit_set[gi];
		assign clr = crit_clr[gi];
		assign crit_nxt[gi] = flag_next(cur, set, clr);
	end

	for (genvar gi = 0; gi < FLAG_N; gi++) begin : g_hot
		logic cur;
		logic set;
		logic clr;
		assign cur = state_reg.hot_flags[gi];
		assign set = hot_set[gi];
		assign clr = hot_clr[gi];
		assign hot_nxt[gi] = flag_next(cur, set, clr);
	end

	// Read data taken before any same-cycle write lands
	assign rd_word = read_word(rd_sel, state_reg.rail_flags,
		state_reg.crit_flags, state_reg.hot_flags);

	// Clock enable low freezes flags and the read port
	always_comb begin
		state_next = state_reg;
		if (CLK_EN) begin
			state_next.rail_flags = rail_nxt;
			state_next.crit_flags = crit_nxt;
			state_next.hot_flags  = hot_nxt;
			state_next.rvalid     = rd_take;
			// RDATA holds between reads
			if (rd_take) begin
				state_next.rdata = rd_word;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign adj_reg1_fault_flag        = state_reg.rail_flags[FTS_B_ADJ1];
	assign termination_reg_fault_flag = state_reg.rail_flags[FTS_B_TERM];
	assign switch_b2_fault_flag       = state_reg.rail_flags[FTS_B_LOAD_SWITCH_B_TWO];
	assign switch_b1_fault_flag       = state_reg.rail_flags[FTS_B_LOAD_SWITCH_B_ONE];
	assign adj_reg3_fault_flag        = state_reg.rail_flags[FTS_B_ADJ3];

	assign rest_of_die_critical_flag     = state_reg.crit_flags[FTS_B_DIE];
	assign termination_reg_critical_flag = state_reg.crit_flags[FTS_B_TERM];
	assign upper_right_critical_flag     = state_reg.crit_flags[FTS_B_URIGHT];
	assign upper_left_critical_flag      = state_reg.crit_flags[FTS_B_ULEFT];
	assign lower_right_critical_flag     = state_reg.crit_flags[FTS_B_LRIGHT];

	assign RDATA      = state_reg.rdata;
	assign RVALID     = state_reg.rvalid;
	assign RAIL_FLAGS[FTS_B_ADJ1]   = adj_reg1_fault_flag;
	assign RAIL_FLAGS[FTS_B_TERM]   = termination_reg_fault_flag;
	assign RAIL_FLAGS[FTS_B_LOAD_SWITCH_B_TWO]   = switch_b2_fault_flag;
	assign RAIL_FLAGS[FTS_B_LOAD_SWITCH_B_ONE]   = switch_b1_fault_flag;
	assign RAIL_FLAGS[FTS_B_ADJ3]   = adj_reg3_fault_flag;
	assign CRIT_FLAGS[FTS_B_DIE]    = rest_of_die_critical_flag;
	assign CRIT_FLAGS[FTS_B_TERM]   = termination_reg_critical_flag;
	assign CRIT_FLAGS[FTS_B_URIGHT] = upper_right_critical_flag;
	assign CRIT_FLAGS[FTS_B_ULEFT]  = upper_left_critical_flag;
	assign CRIT_FLAGS[FTS_B_LRIGHT] = lower_right_critical_flag;
	assign HOT_FLAGS  = state_reg.hot_flags;

endmodule : fts_status_bank

// ---- verification/fts_host.sv ----
// Host model driving one register strobe at a time
module fts_host import fts_pkg::*; (input wire logic CLOCK, output fts_req_t REQ='0);
	timeunit 1ns; timeprecision 100ps;
	task automatic xfer(input logic w, input logic [7:0] a, d);
		@(posedge CLOCK) #2 REQ='{w, !w, a, d};
		@(posedge CLOCK) #2 REQ='0;
	endtask : xfer
endmodule : fts_host

// ---- verification/fts_status_bank_props.sv ----
// Status bank checker
module fts_chk import fts_pkg::*; (input wire logic CLOCK, RST, CLK_EN, RVALID,
	input wire fts_req_t REQ, input wire fts_evt_t EVT, input wire logic [7:0] RDATA,
	input wire logic [4:0] RAIL_FLAGS, CRIT_FLAGS, HOT_FLAGS);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	wire e=CLK_EN, r=e&REQ.rd_en, w=e&REQ.wr_en;
	property p_1; e|=>&(RAIL_FLAGS|~$past(EVT.rail_fault)); endproperty
	a_1: assert property(p_1) else $error("rail");
	property p_4; e|=>&(CRIT_FLAGS|~$past(EVT.over_crit)); endproperty
	a_4: assert property(p_4) else $error("crit");
	property p_7; e|=>&(HOT_FLAGS|~$past(EVT.over_hot)); endproperty
	a_7: assert property(p_7) else $error("hot");
	property p_3; !w|=>&(CRIT_FLAGS|~$past(CRIT_FLAGS)); endproperty
	a_3: assert property(p_3) else $error("hold");
	property p_9; r&&REQ.addr==8'hB3|=>RVALID&&RDATA=={3'h0,$past(RAIL_FLAGS)}; endproperty
	a_9: assert property(p_9) else $error("rd B3");
	property p_10; r&&REQ.addr==8'hB5|=>RVALID&&RDATA=={3'h0,$past(HOT_FLAGS)}; endproperty
	a_10: assert property(p_10) else $error("rd B5");
	property p_8; w&&REQ.addr==8'hB4&&REQ.wdata[4]&&!EVT.over_crit[4]|=>!CRIT_FLAGS[4]; endproperty
	a_8: assert property(p_8) else $error("clear");
	property p_11; RVALID|->RDATA[7:5]==3'h0; endproperty
	a_11: assert property(p_11) else $error("reserved");
	c_1: cover property(r&&REQ.addr==8'hB4);
	c_2: cover property(w&&REQ.addr==8'hB3);
	c_3: cover property(r&&REQ.addr==8'hB6);
	c_4: cover property(!CLK_EN&&REQ.wr_en);
endmodule : fts_chk
bind fts_status_bank fts_chk chk (.*);

// ---- verification/fts_status_bank_tb_top.sv ----
// Random traffic bench with a flag model
module fts_status_bank_tb_top import fts_pkg::*;;
	timeunit 1ns; timeprecision 100ps;
	logic CLOCK=0, RST=1, CLK_EN=1, RVALID, ev=0;
	logic [7:0] RDATA, a, ed=0;
	fts_req_t REQ;
	fts_evt_t EVT='0;
	logic [4:0] m[3]='{0, 0, 0}, F[3];
	int err_count=0, checks_done=0;
	logic [31:0] s=32'hB6D3;
	function automatic logic [31:0] x(); s^=s<<13; s^=s>>17; s^=s<<5; return s; endfunction : x
	fts_host host (.CLOCK, .REQ);
	fts_status_bank dut (.CLOCK, .RST, .CLK_EN, .REQ, .RDATA, .RVALID, .EVT,
		.RAIL_FLAGS(F[0]), .CRIT_FLAGS(F[1]), .HOT_FLAGS(F[2]));
	task automatic cmp_flags(input int k); checks_done++;
		if (F[k]!==m[k]) begin err_count++; $display("unexpected %0t flags %0d", $time, k); end
	endtask : cmp_flags
	task automatic cmp_read(); checks_done++;
		if (RVALID!==ev || (RDATA&{8{ev}})!==ed) begin
			err_count++; $display("unexpected %0t read", $time); end
	endtask : cmp_read
	task automatic end_of_test(); $display("errors %0d checks %0d", err_count, checks_done);
		if (err_count==0 && checks_done>0) $display("DONE - PASS"); else $display("DONE - FAIL");
		$finish; endtask : end_of_test
	initial forever #12.5 CLOCK=~CLOCK;
	// Sparse events so that clears stay visible; enable low about one edge in eight
	always @(posedge CLOCK) #2 begin
		EVT=fts_evt_t'(15'(x()&x()&x()&x()));
		CLK_EN=(x()%8)!=0;
	end
	always @(posedge CLOCK) if (RST) begin
		m='{0, 0, 0}; ev=0; ed=0;
	end else begin
		cmp_flags(0);
		cmp_flags(1);
		cmp_flags(2);
		cmp_read();
		if (CLK_EN) begin
			ev=REQ.rd_en; a=REQ.addr-8'hB3; ed=(ev && a<3) ? {3'h0, m[a]} : 8'h00;
			for (int k=0; k<3; k++) m[k]=m[k]&~((REQ.wr_en && a==k) ? REQ.wdata[4:0] : 5'h00)
				|EVT[14-5*k-:5];
		end
	end
	initial begin
		repeat (12) @(posedge CLOCK);
		#2 RST=0;
		repeat (250) host.xfer(1'(x()), 8'(8'hB2+x()%5), 8'(x()));
		// Second reset in mid-run, flags must return to zero
		@(posedge CLOCK) #2 RST=1;
		repeat (3) @(posedge CLOCK);
		#2 RST=0;
		repeat (250) host.xfer(1'(x()), 8'(8'hB2+x()%5), 8'(x()));
		end_of_test();
	end
endmodule : fts_status_bank_tb_top
